// *** hw/ext_irq_pin_noise_filter.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Nonmaskable pin passes an analog delay; level must persist first.
// - Nonmaskable pin still wakes the device from deepest stop.
// - With system clock stopped, only the analog delay qualifies it.
// - Other maskable pins use the analog delay filter.
// - Filter type bit: 0 analog, 1 digital for the selectable pin.
// - Sample count bit: 0 needs three equal samples, 1 needs two.
// - Clock select 000..100 gives divide 64..1024; 101 the sub clock.
// - Divided sampling clocks halt in idle and stop.
// - With sub clock, digital filtering keeps running in standby.
// - Control register takes byte and single-bit accesses.
// - Reset clears the control register to zero.
// - Pulses shorter than (M-1) sample periods are always rejected.
// - Pulses between (M-1) and M periods may pass, phase dependent.
// - Pulses of at least M sample periods always pass.
// - Filtered levels feed per-pin rising/falling/both/none detectors.
module ext_irq_pin_noise_filter
    import irq_filter_pkg::*;
#(
    parameter int HOLD_CYC = ANALOG_HOLD_CYC
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    input wire logic [STRB_W-1:0] pstrb_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Interrupt pins and power state
    input wire logic nmi_pin_i,
    input wire logic [NUM_MASKABLE-1:0] maskable_irq_pins_i,
    input wire logic sub_clock_i,
    input wire logic standby_i,
    // Towards the interrupt controller
    output logic [NUM_PINS-1:0] filtered_level_o,
    output logic [NUM_PINS-1:0] edge_o
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic edge_hit(input logic prev, input logic cur,
                                      input logic rise, input logic fall);
        edge_hit = (rise && !prev && cur) || (fall && prev && !cur);
    endfunction

    function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] code);
        logic [2:0] shift;
        shift = 3'(CLK_DIV1024 - code);
        div_mask = {PRESC_W{1'b1}} >> shift;
    endfunction

    // ------------------------------------------------------------
    // Bus request decode
    // ------------------------------------------------------------
    apb_req_type req;
    logic setup_ph;
    logic access_ph;
    logic hit_ctrl;
    logic hit_rise;
    logic hit_fall;
    logic hit_stat;
    logic addr_hit;
    logic wr_en;
    logic wr_lane0;
    logic wr_lane1;

    assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i,
                   addr: paddr_i, wdata: pwdata_i, strb: pstrb_i};
    assign setup_ph = req.sel && !req.enable;
    assign access_ph = req.sel && req.enable;
    assign hit_ctrl = req.addr == NOISE_CTRL_OFS;
    assign hit_rise = req.addr == EDGE_RISE_OFS;
    assign hit_fall = req.addr == EDGE_FALL_OFS;
    assign hit_stat = req.addr == LEVEL_STAT_OFS;
    assign addr_hit = hit_ctrl || hit_rise || hit_fall || hit_stat;
    assign wr_en = access_ph && req.write && addr_hit;
    // Byte lanes let software change the low byte alone; the core's
    // bit-set and bit-clear operations arrive as read-modify-write bytes.
    assign wr_lane0 = wr_en && req.strb[0];
    assign wr_lane1 = wr_en && req.strb[1];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    noise_ctrl_type ctrl_q;
    noise_ctrl_type ctrl_d;
    logic [NUM_PINS-1:0] rise_sel_q;
    logic [NUM_PINS-1:0] rise_sel_d;
    logic [NUM_PINS-1:0] fall_sel_q;
    logic [NUM_PINS-1:0] fall_sel_d;
    logic [NUM_PINS-1:0] wr_pins;
    logic [NUM_PINS-1:0] wmask_pins;

    assign wr_pins = pwdata_i[NUM_PINS-1:0];
    assign wmask_pins = {wr_lane1, {(NUM_PINS-1){wr_lane0}}};

    assign ctrl_d = (wr_lane0 && hit_ctrl)
        ? noise_ctrl_type'(pwdata_i[7:0] & NOISE_CTRL_WMASK)
        : ctrl_q;
    assign rise_sel_d = hit_rise
        ? (rise_sel_q & ~wmask_pins) | (wr_pins & wmask_pins)
        : rise_sel_q;
    assign fall_sel_d = hit_fall
        ? (fall_sel_q & ~wmask_pins) | (wr_pins & wmask_pins)
        : fall_sel_q;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_q <= noise_ctrl_type'(NOISE_CTRL_RST);
            rise_sel_q <= EDGE_SEL_RST;
            fall_sel_q <= EDGE_SEL_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rise_sel_q <= rise_sel_d;
            fall_sel_q <= fall_sel_d;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rd_mux;
    logic [NUM_PINS-1:0] level_q;

    // Read data is captured in the setup cycle so that the access cycle
    // can complete at once with a registered value on the bus.
    always_comb
    begin
        rd_mux = '0;
        if (hit_ctrl)
        begin
            rd_mux = DATA_W'(ctrl_q);
        end
        else if (hit_rise)
        begin
            rd_mux = DATA_W'(rise_sel_q);
        end
        else if (hit_fall)
        begin
            rd_mux = DATA_W'(fall_sel_q);
        end
        else if (hit_stat)
        begin
            rd_mux = DATA_W'(level_q);
        end
    end

    assign rdata_d = (setup_ph && !req.write) ? rd_mux : rdata_q;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata_o = rdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = access_ph && !addr_hit;

    // ------------------------------------------------------------
    // Sampling clock
    // ------------------------------------------------------------
    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_d;
    logic sub_prev_q;
    logic sub_rise;
    logic div_tick;
    logic sample_tick;
    samp_clk_type clk_sel;

    assign clk_sel = samp_clk_type'(ctrl_q.sampling_clock_select);
    // The prescaler freezes in standby, as the system clock would.
    assign presc_d = standby_i ? presc_q : presc_q + 1'b1;
    assign div_tick = !standby_i &&
        ((presc_q & div_mask(clk_sel)) == div_mask(clk_sel));
    assign sub_rise = sub_clock_i && !sub_prev_q;

    always_comb
    begin
        case (clk_sel)
            CLK_DIV64,
            CLK_DIV128,
            CLK_DIV256,
            CLK_DIV512,
            CLK_DIV1024: sample_tick = div_tick;
            CLK_SUB: sample_tick = sub_rise;
            // Prohibited codes simply stop sampling.
            default: sample_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            presc_q <= '0;
            sub_prev_q <= 1'b0;
        end
        else
        begin
            presc_q <= presc_d;
            sub_prev_q <= sub_clock_i;
        end
    end

    // ------------------------------------------------------------
    // Noise filters
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] raw_pins;
    logic [NUM_PINS-1:0] analog_lvl;
    logic digital_lvl;
    logic [NUM_PINS-1:0] filt_lvl;

    assign raw_pins = {maskable_irq_pins_i, nmi_pin_i};

    for (genvar g = 0; g < NUM_PINS; g++)
    begin : g_analog
        analog_delay_filter #(
            .HOLD_CYC(HOLD_CYC)
        ) u_analog (
            .clk_i(clk_i),
            .resetn_i(resetn_i),
            .pin_i(raw_pins[g]),
            .bypass_i(standby_i),
            .level_o(analog_lvl[g])
        );
    end

    digital_sample_filter u_digital (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(maskable_irq_pins_i[SEL_PIN]),
        .tick_i(sample_tick),
        .two_samples_i(ctrl_q.sample_count_select),
        .level_o(digital_lvl)
    );

    always_comb
    begin
        filt_lvl = analog_lvl;
        if (ctrl_q.filter_type_select)
        begin
            filt_lvl[SEL_PIN + 1] = digital_lvl;
        end
    end

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] edge_q;
    logic [NUM_PINS-1:0] edge_d;

    always_comb
    begin
        for (int i = 0; i < NUM_PINS; i++)
        begin
            edge_d[i] = edge_hit(level_q[i], filt_lvl[i],
                                 rise_sel_q[i], fall_sel_q[i]);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            level_q <= '0;
            edge_q <= '0;
        end
        else
        begin
            level_q <= filt_lvl;
            edge_q <= edge_d;
        end
    end

    assign filtered_level_o = level_q;
    assign edge_o = edge_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_RSV_ZERO: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $changed(ctrl_q) |-> ctrl_q.reserved == 3'b000)
        else $error("Reserved control bits became set.");

    AST_STRB_GATE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        access_ph && req.write && hit_ctrl && !req.strb[0] |=>
            $stable(ctrl_q))
        else $error("Control changed on a write without its byte lane.");

    AST_DIV_HALT: assert property (@(posedge clk_i) disable iff (!resetn_i)
        standby_i && clk_sel != CLK_SUB |-> !sample_tick)
        else $error("Divided sampling clock ticked in standby.");

    AST_SUB_RUN: assert property (@(posedge clk_i) disable iff (!resetn_i)
        clk_sel == CLK_SUB && sub_clock_i && !sub_prev_q |->
            sample_tick)
        else $error("Sub clock edge did not produce a sample.");

    AST_DIV64_GAP: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sample_tick && clk_sel == CLK_DIV64 && $stable(clk_sel) |=>
            (!sample_tick || clk_sel == CLK_SUB) [*8])
        else $error("Divide-by-64 sampling ticked too early.");

    AST_ANALOG_SEL: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !ctrl_q.filter_type_select |->
            filt_lvl[SEL_PIN + 1] == analog_lvl[SEL_PIN + 1])
        else $error("Selectable pin left the analog path.");

    AST_NO_EDGE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !rise_sel_q[NMI_IDX] && !fall_sel_q[NMI_IDX] |=>
            !edge_q[NMI_IDX])
        else $error("Edge reported with detection disabled.");

    AST_RISE_EDGE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rise_sel_q[NMI_IDX] && !level_q[NMI_IDX] && filt_lvl[NMI_IDX] |=>
            edge_q[NMI_IDX] && level_q[NMI_IDX])
        else $error("Rising edge on the filtered level was missed.");

    AST_WAKE_PATH: assert property (@(posedge clk_i) disable iff (!resetn_i)
        standby_i |-> analog_lvl[NMI_IDX] == nmi_pin_i)
        else $error("Nonmaskable pin not passed through in stop.");

endmodule

// *** include/irq_filter_pkg.sv ***
package irq_filter_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    // Persistence time standing in for the analog delay element.
    localparam int ANALOG_HOLD_NS = 200;
    localparam int ANALOG_HOLD_CYC =
        (ANALOG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam logic [7:0] NOISE_CTRL_OFS = 8'h00;
    localparam logic [7:0] EDGE_RISE_OFS = 8'h04;
    localparam logic [7:0] EDGE_FALL_OFS = 8'h08;
    localparam logic [7:0] LEVEL_STAT_OFS = 8'h0c;
    localparam logic [7:0] NOISE_CTRL_RST = 8'h00;
    localparam logic [7:0] NOISE_CTRL_WMASK = 8'hc7;
    localparam logic [8:0] EDGE_SEL_RST = 9'h000;

    // ------------------------------------------------------------
    // Pins and prescaler
    // ------------------------------------------------------------
    localparam int NUM_MASKABLE = 8;
    localparam int NUM_PINS = NUM_MASKABLE + 1;
    localparam int NMI_IDX = 0;
    localparam int SEL_PIN = 3;
    localparam int PRESC_W = 10;

    typedef enum logic [2:0] {
        CLK_DIV64 = 3'b000,
        CLK_DIV128 = 3'b001,
        CLK_DIV256 = 3'b010,
        CLK_DIV512 = 3'b011,
        CLK_DIV1024 = 3'b100,
        CLK_SUB = 3'b101
    } samp_clk_type;

    typedef struct packed {
        logic filter_type_select;
        logic sample_count_select;
        logic [2:0] reserved;
        logic [2:0] sampling_clock_select;
    } noise_ctrl_type;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] strb;
    } apb_req_type;

endpackage

// *** hw/analog_delay_filter.sv ***
`timescale 1ns/100ps
module analog_delay_filter
    import irq_filter_pkg::*;
#(
    parameter int HOLD_CYC = ANALOG_HOLD_CYC
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Pin side
    input wire logic pin_i,
    input wire logic bypass_i,
    // Filtered level
    output logic level_o
);

    localparam int CNT_W = $clog2(HOLD_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HOLD_CYC - 1);

    logic level_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic differs;
    logic settled;

    assign differs = pin_i != level_q;
    assign settled = differs && (cnt_q == CNT_LAST);
    assign cnt_d = differs ? cnt_q + 1'b1 : '0;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            level_q <= 1'b0;
            cnt_q <= '0;
        end
        else if (bypass_i || settled)
        begin
            level_q <= pin_i;
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    // While the system clock is halted the delay element alone qualifies
    // the pin, so the level bypasses the clocked counter.
    assign level_o = bypass_i ? pin_i : level_q;

    AST_ANA_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $changed(level_q) && !$past(bypass_i) |->
            $past(cnt_q) == CNT_LAST)
        else $error("Analog level changed before the hold time.");

endmodule

// *** hw/digital_sample_filter.sv ***
`timescale 1ns/100ps
module digital_sample_filter
    import irq_filter_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Pin and sampling control
    input wire logic pin_i,
    input wire logic tick_i,
    input wire logic two_samples_i,
    // Filtered level
    output logic level_o
);

    logic sync1_q;
    logic sync2_q;
    logic [1:0] hist_q;
    logic level_q;
    logic match2;
    logic match3;
    logic accept;

    assign match2 = sync2_q == hist_q[0];
    assign match3 = match2 && (sync2_q == hist_q[1]);
    assign accept = tick_i && (two_samples_i ? match2 : match3);

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            hist_q <= '0;
            level_q <= 1'b0;
        end
        else
        begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            if (tick_i)
            begin
                hist_q <= {hist_q[0], sync2_q};
            end
            if (accept)
            begin
                level_q <= sync2_q;
            end
        end
    end

    assign level_o = level_q;

    AST_DIG_TWO: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $changed(level_q) |->
            $past(tick_i) && $past(hist_q[0]) == level_q)
        else $error("Digital level changed without two equal samples.");

    AST_DIG_THREE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $changed(level_q) && !$past(two_samples_i) |->
            $past(hist_q[1]) == level_q)
        else $error("Digital level changed without three equal samples.");

endmodule

// *** verification/irq_source_model.sv ***
`timescale 1ns/100ps
module irq_source_model
    import irq_filter_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Pins towards the filter
    output logic nmi_pin_o,
    output logic [NUM_MASKABLE-1:0] maskable_irq_pins_o,
    output logic sub_clock_o
);
    logic [NUM_PINS-1:0] pins_q = '0;
    logic sub_run_q = 1'b0;
    logic [3:0] sub_cnt_q = 4'h0;
    logic sub_q = 1'b0;

    assign nmi_pin_o = pins_q[0];
    assign maskable_irq_pins_o = pins_q[NUM_PINS-1:1];
    assign sub_clock_o = sub_q;

    // The sub clock period is twenty system cycles; it stands low when off.
    always @(posedge clk_i)
    begin
        if (!sub_run_q)
        begin
            sub_cnt_q <= 4'h0;
            sub_q <= 1'b0;
        end
        else if (sub_cnt_q == 4'h9)
        begin
            sub_cnt_q <= 4'h0;
            sub_q <= ~sub_q;
        end
        else
            sub_cnt_q <= sub_cnt_q + 4'h1;
    end

    task automatic sub_run(input logic on);
        @(posedge clk_i);
        sub_run_q <= on;
    endtask

    // Holds one pin at a steady level until the next call changes it.
    task automatic drive(input int idx, input logic lvl);
        @(posedge clk_i);
        pins_q[idx] <= lvl;
    endtask

    // Pulses meant to be seen are held for the full sampling depth.
    task automatic pulse(input int idx, input int width);
        @(posedge clk_i);
        pins_q[idx] <= 1'b1;
        repeat (width) @(posedge clk_i);
        pins_q[idx] <= 1'b0;
    endtask
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    import irq_filter_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i, psel, penable, pwrite, standby;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [STRB_W-1:0] pstrb;
    logic pready, pslverr, nmi_pin, sub_clock;
    logic [NUM_MASKABLE-1:0] mpins;
    logic [NUM_PINS-1:0] flevel, edges;
    logic [31:0] edge_cnt [NUM_PINS];
    int mismatches = 0;
    int comparisons = 0;

    always #20 clk_i = ~clk_i;

    always @(posedge clk_i)
        for (int i = 0; i < NUM_PINS; i++)
            if (edges[i] === 1'b1)
                edge_cnt[i] <= edge_cnt[i] + 32'h1;

    // A short hold time keeps the analog cases brief.
    ext_irq_pin_noise_filter #(.HOLD_CYC(2)) ext_irq_pin_noise_filter_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .nmi_pin_i(nmi_pin),
        .maskable_irq_pins_i(mpins), .sub_clock_i(sub_clock),
        .standby_i(standby), .filtered_level_o(flevel), .edge_o(edges));

    irq_source_model irq_source_model_inst (
        .clk_i(clk_i), .nmi_pin_o(nmi_pin),
        .maskable_irq_pins_o(mpins), .sub_clock_o(sub_clock));

    // ------------------------------------------------------------
    // Bus and comparison tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        if (n >= 100)
            mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, 4'hf, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, 4'hf, r, e);
        check(r, exp);
    endtask

    task automatic pulse_chk(input int p, input int width, input int settle,
                             input logic [31:0] exp);
        logic [31:0] base;
        base = edge_cnt[p];
        irq_source_model_inst.pulse(p, width);
        repeat (settle) @(posedge clk_i);
        check(edge_cnt[p] - base, exp);
    endtask

    // Only clock codes 000 to 101 are ever written here.
    task automatic dig(input logic [7:0] ctrl, input int width,
                       input int period, input logic [31:0] exp);
        wr(NOISE_CTRL_OFS, {24'h0, ctrl});
        pulse_chk(SEL_PIN + 1, width, 3 * period + 20, exp);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end

    initial
    begin
        logic [31:0] r;
        logic e;
        resetn_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        standby = 1'b0;
        for (int i = 0; i < NUM_PINS; i++)
            edge_cnt[i] = 32'h0;
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd_chk(NOISE_CTRL_OFS, 32'h0);
        rd_chk(EDGE_RISE_OFS, 32'h0);
        rd_chk(EDGE_FALL_OFS, 32'h0);
        pulse_chk(0, 6, 10, 32'h0);
        wr(NOISE_CTRL_OFS, 32'hfd);
        rd_chk(NOISE_CTRL_OFS, 32'hc5);
        apb(1'b1, NOISE_CTRL_OFS, 32'h0, 4'h0, r, e);
        rd_chk(NOISE_CTRL_OFS, 32'hc5);
        apb(1'b0, 8'h10, 32'h0, 4'hf, r, e);
        check({31'h0, e}, 32'h1);
        check(r, 32'h0);
        wr(NOISE_CTRL_OFS, 32'h0);
        wr(EDGE_RISE_OFS, 32'h1ff);
        wr(EDGE_FALL_OFS, 32'h1ff);
        for (int p = 0; p < NUM_PINS; p++)
        begin
            pulse_chk(p, 1, 10, 32'h0);
            pulse_chk(p, 6, 10, 32'h2);
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(EDGE_RISE_OFS, {30'h0, k[0], 1'b0});
            wr(EDGE_FALL_OFS, {30'h0, k[1], 1'b0});
            pulse_chk(1, 6, 10, 32'(k[0]) + 32'(k[1]));
        end
        wr(EDGE_RISE_OFS, 32'h1ff);
        wr(EDGE_FALL_OFS, 32'h1ff);
        for (int c = 0; c < 5; c++)
        begin
            dig(8'hc0 | 8'(c), (64 << c) - 4, 64 << c, 32'h0);
            dig(8'hc0 | 8'(c), 128 << c, 64 << c, 32'h2);
        end
        dig(8'h80, 120, 64, 32'h0);
        dig(8'h80, 192, 64, 32'h2);
        irq_source_model_inst.sub_run(1'b1);
        dig(8'hc5, 16, 20, 32'h0);
        dig(8'hc5, 44, 20, 32'h2);
        standby <= 1'b1;
        dig(8'hc5, 44, 20, 32'h2);
        dig(8'hc0, 200, 64, 32'h0);
        pulse_chk(0, 6, 10, 32'h2);
        standby <= 1'b0;
        irq_source_model_inst.drive(2, 1'b1);
        repeat (10) @(posedge clk_i);
        check({23'h0, flevel}, 32'h004);
        rd_chk(LEVEL_STAT_OFS, 32'h004);
        irq_source_model_inst.drive(2, 1'b0);
        repeat (10) @(posedge clk_i);
        check({23'h0, flevel}, 32'h000);
        rd_chk(LEVEL_STAT_OFS, 32'h0);
        print_verdict();
    end
endmodule
